// >>> inc/spipin_pkg.sv
// shared constants and carriers for the spi pin port
package spipin_pkg;

    // data word and buffer shape
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int BIT_CNT_W = 4;
    localparam int BITS_PER_WORD = 8;

    // pin positions in the shared port vectors
    localparam int PIN_SCLK = 0; // port_e_line_four
    localparam int PIN_MOSI = 1; // port_e_line_five
    localparam int PIN_MISO = 2; // port_e_line_six
    localparam int PIN_SS = 3; // port_e_line_seven
    localparam int PIN_CNT = 4;

    // idle fill word and reset value
    localparam logic [DATA_W-1:0] IDLE_WORD = 8'h00;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // master serial clock timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS = 40;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 8;

    // one pin driver: level and enable
    typedef struct packed {
        logic o;
        logic oe;
    } spipin_pin_t;

    // static configuration from the surrounding logic
    typedef struct packed {
        logic master;
        logic [PIN_CNT-1:0] gpio_sel;
        logic [PIN_CNT-1:0] gpio_dir;
        logic [PIN_CNT-1:0] gpio_out;
    } spipin_cfg_t;

    // transfer sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SHIFT = 3'h2,
        ST_FAULT = 3'h4
    } spipin_state_t;

endpackage : spipin_pkg

// >>> rtl/spipin_fifo.sv
`timescale 1ns/10ps
`default_nettype none
// synchronous word fifo with valid/ready on both sides
module spipin_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // word storage
    logic [AW-1:0] wr_ptr_r; // next slot to write
    logic [AW-1:0] rd_ptr_r; // oldest word
    logic [AW:0] cnt_r; // words held
    logic [AW:0] cnt_nxt;
    logic full_r; // registered full flag
    logic empty_r; // registered empty flag
    logic push;
    logic pop;

    // handshakes come from the registered flags
    assign in_ready = !full_r;
    assign out_valid = !empty_r;
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && !full_r;
    assign pop = out_ready && !empty_r;
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    // storage write, no reset needed
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers, count and flags
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            full_r <= 1'h0;
            empty_r <= 1'h1;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            cnt_r <= cnt_nxt;
            full_r <= (cnt_nxt == (AW+1)'(DEPTH));
            empty_r <= (cnt_nxt == '0);
        end
    end

endmodule : spipin_fifo
`default_nettype wire

// >>> rtl/spipin_top.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1 - miso input as master, driven as slave
// R2 - unselected slave releases miso to high impedance
// R3 - mosi driven as master, input as slave
// R4 - mosi bit stable half period before capture
// R5 - master drives serial clock out
// R6 - slave takes serial clock as data clock
// R7 - master uses select only for arbitration
// R8 - slave works only while selected
// R9 - pins come up in spi function after reset
// R10 - general-purpose pins individually input or output
// R11 - select is active low
// R12 - select low in master: release, flag fault
module spipin_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // configuration
    input wire spipin_pkg::spipin_cfg_t cfg,
    // transmit stream into the buffer
    input wire logic tx_valid,
    input wire logic [spipin_pkg::DATA_W-1:0] tx_data,
    output logic tx_ready,
    // receive stream
    output logic rx_valid,
    output logic [spipin_pkg::DATA_W-1:0] rx_data,
    // status
    output logic mode_fault,
    input wire logic mode_fault_clr,
    output logic busy,
    // pin inputs
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic ss_n_i,
    // pin drivers
    output spipin_pkg::spipin_pin_t sclk_pin,
    output spipin_pkg::spipin_pin_t mosi_pin,
    output spipin_pkg::spipin_pin_t miso_pin,
    output spipin_pkg::spipin_pin_t ss_pin,
    // synchronised pin levels for general-purpose reads
    output logic [spipin_pkg::PIN_CNT-1:0] gpio_in
);
    localparam int DW = spipin_pkg::DATA_W;

    logic [spipin_pkg::PIN_CNT-1:0] pin_meta_r; // first sync stage only
    logic [spipin_pkg::PIN_CNT-1:0] pin_sync_r; // second sync stage
    logic sclk_prev_r; // previous synchronised clock level
    spipin_pkg::spipin_state_t state_r;
    spipin_pkg::spipin_state_t state_nxt;
    logic [DW-1:0] tx_sh_r; // outgoing shift register
    logic [DW-1:0] rx_sh_r; // incoming shift register
    logic [spipin_pkg::BIT_CNT_W-1:0] cnt_r; // bits captured in this word
    logic [spipin_pkg::DIV_W-1:0] div_r; // half period counter
    logic sclk_r; // master clock level
    logic mode_fault_r;
    logic rx_valid_r;
    logic [DW-1:0] rx_data_r;
    logic busy_r;
    logic fifo_valid;
    logic [DW-1:0] fifo_data;
    logic ss_n_eff; // select as seen by the spi logic
    logic fault_now; // another master holds the bus
    logic half_done;
    logic rise;
    logic fall;
    logic din;
    logic word_done;
    logic load;
    logic pop;

    // function picks the spi or port drive of one pin
    function automatic spipin_pkg::spipin_pin_t pin_drive(
        input logic sel, input logic dir, input logic gout, input logic so, input logic soe);
        spipin_pkg::spipin_pin_t p;
        p.o = sel ? gout : so;
        p.oe = sel ? dir : soe;
        return p;
    endfunction : pin_drive

    // transmit buffer between the user and the shifter
    spipin_fifo #(
        .WIDTH(DW),
        .DEPTH(spipin_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    // two-stage synchroniser for all four pins
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            // idle levels: select high, clock low, so no false clock edge follows reset
            pin_meta_r <= 4'h8;
            pin_sync_r <= 4'h8;
            sclk_prev_r <= 1'h0;
        end
        else
        begin
            pin_meta_r <= {ss_n_i, miso_i, mosi_i, sclk_i};
            pin_sync_r <= pin_meta_r;
            sclk_prev_r <= pin_sync_r[spipin_pkg::PIN_SCLK];
        end
    end

    // select is low-active; a port-function select pin reads as idle
    assign ss_n_eff = cfg.gpio_sel[spipin_pkg::PIN_SS] | pin_sync_r[spipin_pkg::PIN_SS]; // [R11]
    // as master the select only signals a competing master
    assign fault_now = cfg.master && !ss_n_eff; // [R7] [R12]
    assign half_done = (div_r == spipin_pkg::DIV_W'(spipin_pkg::SCLK_HALF_CYC - 1));
    assign word_done = (cnt_r == spipin_pkg::BIT_CNT_W'(spipin_pkg::BITS_PER_WORD));
    assign din = cfg.master ? pin_sync_r[spipin_pkg::PIN_MISO] : pin_sync_r[spipin_pkg::PIN_MOSI];

    // capture and shift strobes: own divider as master, sampled clock as slave
    always_comb
    begin
        if (cfg.master)
        begin
            rise = (state_r == spipin_pkg::ST_SHIFT) && !fault_now && half_done && !sclk_r; // [R5]
            fall = (state_r == spipin_pkg::ST_SHIFT) && !fault_now && half_done && sclk_r;
        end
        else
        begin
            rise = (state_r == spipin_pkg::ST_SHIFT) && !ss_n_eff
                && pin_sync_r[spipin_pkg::PIN_SCLK] && !sclk_prev_r; // [R6] [R8]
            fall = (state_r == spipin_pkg::ST_SHIFT) && !ss_n_eff
                && !pin_sync_r[spipin_pkg::PIN_SCLK] && sclk_prev_r; // [R6] [R8]
        end
    end

    // sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            spipin_pkg::ST_IDLE:
            begin
                if (fault_now)
                    state_nxt = spipin_pkg::ST_FAULT; // [R12]
                else if (cfg.master ? fifo_valid : !ss_n_eff)
                    state_nxt = spipin_pkg::ST_SHIFT; // [R8]
            end
            spipin_pkg::ST_SHIFT:
            begin
                if (fault_now)
                    state_nxt = spipin_pkg::ST_FAULT; // [R12]
                else if (!cfg.master && ss_n_eff)
                    state_nxt = spipin_pkg::ST_IDLE; // [R8]
                else if (cfg.master && fall && word_done)
                    state_nxt = spipin_pkg::ST_IDLE;
            end
            spipin_pkg::ST_FAULT:
            begin
                if (!cfg.master || (!mode_fault_r && ss_n_eff))
                    state_nxt = spipin_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = spipin_pkg::ST_IDLE;
            end
        endcase
    end

    // new word: at the start of a transfer, or a slave's next word after eight bits
    assign load = ((state_r == spipin_pkg::ST_IDLE) && (state_nxt == spipin_pkg::ST_SHIFT))
        || (!cfg.master && fall && word_done && (state_nxt == spipin_pkg::ST_SHIFT));
    assign pop = load && fifo_valid;

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            state_r <= spipin_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // master clock divider and level, low between words; counting starts in the first shift cycle
    // so the first bit also gets a full half period ahead of the first rise
    always_ff @(posedge clk_sys)
    begin
        if (srst || !cfg.master || state_r != spipin_pkg::ST_SHIFT || state_nxt != spipin_pkg::ST_SHIFT) // [R4]
        begin
            div_r <= '0;
            sclk_r <= 1'h0;
        end
        else if (state_r == spipin_pkg::ST_SHIFT && half_done)
        begin
            div_r <= '0;
            sclk_r <= !sclk_r; // [R5]
        end
        else
        begin
            div_r <= div_r + spipin_pkg::DIV_W'(1);
        end
    end

    // shifters: first bit out on load, next bits on falling edges, capture on rising
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            tx_sh_r <= spipin_pkg::DATA_RST;
            rx_sh_r <= spipin_pkg::DATA_RST;
            cnt_r <= '0;
        end
        else
        begin
            if (load)
            begin
                tx_sh_r <= fifo_valid ? fifo_data : spipin_pkg::IDLE_WORD;
                cnt_r <= '0;
            end
            else if (fall)
            begin
                tx_sh_r <= {tx_sh_r[DW-2:0], 1'h0}; // [R4]
            end
            else if (rise)
            begin
                rx_sh_r <= {rx_sh_r[DW-2:0], din};
                cnt_r <= cnt_r + spipin_pkg::BIT_CNT_W'(1);
            end
        end
    end

    // received word, one-cycle strobe on the eighth capture
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rx_valid_r <= 1'h0;
            rx_data_r <= spipin_pkg::DATA_RST;
        end
        else
        begin
            rx_valid_r <= rise && (cnt_r == spipin_pkg::BIT_CNT_W'(spipin_pkg::BITS_PER_WORD - 1));
            if (rise)
                rx_data_r <= {rx_sh_r[DW-2:0], din};
        end
    end

    // sticky mode fault, a new fault wins over the clear
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            mode_fault_r <= 1'h0;
        else if (fault_now)
            mode_fault_r <= 1'h1; // [R12]
        else if (mode_fault_clr)
            mode_fault_r <= 1'h0;
    end

    // pin drivers; reset leaves every pin undriven in its spi function
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sclk_pin <= '0; // [R9]
            mosi_pin <= '0; // [R9]
            miso_pin <= '0; // [R9]
            ss_pin <= '0; // [R9]
            busy_r <= 1'h0;
        end
        else
        begin
            // port function: per-pin direction and level [R10]
            sclk_pin <= pin_drive(cfg.gpio_sel[0], cfg.gpio_dir[0], cfg.gpio_out[0],
                sclk_r, cfg.master && !fault_now && state_r != spipin_pkg::ST_FAULT); // [R5] [R6]
            mosi_pin <= pin_drive(cfg.gpio_sel[1], cfg.gpio_dir[1], cfg.gpio_out[1],
                tx_sh_r[DW-1], cfg.master && !fault_now && state_r != spipin_pkg::ST_FAULT); // [R3]
            miso_pin <= pin_drive(cfg.gpio_sel[2], cfg.gpio_dir[2], cfg.gpio_out[2],
                tx_sh_r[DW-1], !cfg.master && !ss_n_eff); // [R1] [R2]
            ss_pin <= pin_drive(cfg.gpio_sel[3], cfg.gpio_dir[3], cfg.gpio_out[3], 1'h0, 1'h0);
            busy_r <= (state_nxt == spipin_pkg::ST_SHIFT);
        end
    end

    // outputs straight from flip-flops
    assign rx_valid = rx_valid_r;
    assign rx_data = rx_data_r;
    assign mode_fault = mode_fault_r;
    assign busy = busy_r;
    assign gpio_in = pin_sync_r;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_master_spi(int k);
        cfg.master && !cfg.gpio_sel[k];
    endsequence

    sequence s_sclk_rise;
        $rose(sclk_pin.o) && sclk_pin.oe && cfg.master && !cfg.gpio_sel[0] && !cfg.gpio_sel[1];
    endsequence

    a_miso_master_in: assert property (s_master_spi(2) |=> !miso_pin.oe) // [R1]
        else $error("miso driven in master role");
    a_miso_slave_hiz: assert property (!cfg.master && !cfg.gpio_sel[2] && ss_n_eff |=> !miso_pin.oe) // [R2]
        else $error("unselected slave drives miso");
    a_mosi_role_dir: assert property (!cfg.master && !cfg.gpio_sel[1] |=> !mosi_pin.oe) // [R3]
        else $error("mosi driven in slave role");
    a_mosi_setup_hold: assert property (s_sclk_rise |-> mosi_pin.o == $past(mosi_pin.o, 4)) // [R4]
        else $error("mosi changed too close to clock rise");
    a_sclk_master_out: assert property (cfg.master && !cfg.gpio_sel[0] && !fault_now // [R5]
        && state_r != spipin_pkg::ST_FAULT |=> sclk_pin.oe)
        else $error("master not driving serial clock");
    a_sclk_slave_in: assert property (!cfg.master && !cfg.gpio_sel[0] |=> !sclk_pin.oe) // [R6]
        else $error("slave drives serial clock");
    a_slave_deselect_quiet: assert property (!cfg.master && ss_n_eff |=> !rx_valid_r ##1 !rx_valid_r) // [R8]
        else $error("unselected slave produced a word");
    a_reset_spi_pins: assert property (disable iff (1'b0) srst |=> !sclk_pin.oe && !mosi_pin.oe // [R9]
        && !miso_pin.oe && !ss_pin.oe)
        else $error("pin driven after reset");
    a_gpio_pin_dir: assert property (cfg.gpio_sel[1] |=> mosi_pin.oe == $past(cfg.gpio_dir[1]) // [R10]
        && mosi_pin.o == $past(cfg.gpio_out[1]))
        else $error("port pin direction not followed");
    a_fault_release: assert property (cfg.master && !cfg.gpio_sel[0] && !cfg.gpio_sel[1] // [R7] [R11] [R12]
        && !cfg.gpio_sel[3] && !pin_sync_r[3] |=> mode_fault_r && !mosi_pin.oe && !sclk_pin.oe)
        else $error("mode fault not raised or bus not released");

endmodule : spipin_top
`default_nettype wire

// >>> tb/spipin_partner.sv
`timescale 1ns/10ps
`default_nettype none
// far-side spi device: slave responder or second master, plus wire levels
module spipin_partner (
    // clock for released-line patterns
    input wire logic clk_sys,
    // device pin drivers
    input wire spipin_pkg::spipin_pin_t sclk_pin,
    input wire spipin_pkg::spipin_pin_t mosi_pin,
    input wire spipin_pkg::spipin_pin_t miso_pin,
    input wire spipin_pkg::spipin_pin_t ss_pin,
    // resolved wire levels
    output logic sclk_w,
    output logic mosi_w,
    output logic miso_w,
    output logic ss_n_w
);
    logic s_on = 1'b0; // answering as slave
    logic m_on = 1'b0; // clocking as master
    logic ss_low = 1'b0; // pulls select low
    logic m_sclk = 1'b0;
    logic m_mosi = 1'b0;
    logic [7:0] txsh = 8'h00; // slave shift-out
    logic [7:0] rsh = 8'h00; // slave shift-in
    logic mosi_l = 1'b0;
    logic miso_l = 1'b0;
    int nf = 0;
    int nr = 0;
    int n_late = 0; // data changed too close to a rise
    realtime t_mosi = 0.0;
    logic [7:0] rep_q[$]; // slave replies
    logic [7:0] srx_q[$]; // slave captures
    logic [7:0] mq[$]; // master words out
    logic [7:0] mr[$]; // master words in

    // released data lines show a changing pattern
    always_ff @(posedge clk_sys)
    begin
        mosi_l <= mosi_w;
        miso_l <= miso_w;
    end
    // clock pulled down, select pulled up
    assign sclk_w = sclk_pin.oe ? sclk_pin.o : (m_on & m_sclk);
    assign mosi_w = mosi_pin.oe ? mosi_pin.o : (m_on ? m_mosi : ~mosi_l);
    assign miso_w = miso_pin.oe ? miso_pin.o : (s_on ? txsh[7] : ~miso_l);
    assign ss_n_w = ss_pin.oe ? ss_pin.o : ~ss_low;

    always @(mosi_w) t_mosi = $realtime;

    // slave capture on rise, mode 0
    always @(posedge sclk_w)
    begin
        if (s_on)
        begin
            if ($realtime - t_mosi < 40.0)
                n_late++;
            rsh = {rsh[6:0], mosi_w};
            nr++;
            if (nr == 8)
            begin
                srx_q.push_back(rsh);
                nr = 0;
            end
        end
    end
    // slave shift on fall, next reply after the eighth
    always @(negedge sclk_w)
    begin
        if (s_on)
        begin
            nf++;
            if (nf == 8)
            begin
                txsh = rep_q.size() ? rep_q.pop_front() : 8'h00;
                nf = 0;
            end
            else
                txsh = txsh << 1;
        end
    end

    // second master: n words, select low when sel
    task automatic mxfer(input int n, input logic sel);
        logic [7:0] b;
        logic [7:0] r;
        m_on = 1'b1;
        ss_low = sel;
        #103;
        repeat (n)
        begin
            b = mq.pop_front();
            for (int i = 7; i >= 0; i--)
            begin
                m_mosi = b[i];
                #40 m_sclk = 1'b1;
                r = {r[6:0], miso_w};
                #40 m_sclk = 1'b0;
            end
            mr.push_back(r);
            #80;
        end
        ss_low = 1'b0;
        m_on = 1'b0;
    endtask : mxfer
endmodule : spipin_partner
`default_nettype wire

// >>> tb/spi_pin_interface_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
// self-checking bench for the spi pin port
module spi_pin_interface_tb;
    logic clk_sys;
    logic srst;
    spipin_pkg::spipin_cfg_t cfg;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;
    logic rx_valid;
    logic [7:0] rx_data;
    logic mode_fault;
    logic mode_fault_clr;
    logic busy;
    logic sclk_w;
    logic mosi_w;
    logic miso_w;
    logic ss_n_w;
    spipin_pkg::spipin_pin_t sclk_pin;
    spipin_pkg::spipin_pin_t mosi_pin;
    spipin_pkg::spipin_pin_t miso_pin;
    spipin_pkg::spipin_pin_t ss_pin;
    logic [3:0] gpio_in;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int k;
    int seed;
    logic [7:0] ew[$]; // words sent by the device
    logic [7:0] rp[$]; // words sent to the device
    logic [7:0] rxq[$]; // words the device received

    spipin_top dut (.clk_sys(clk_sys), .srst(srst), .cfg(cfg), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .mode_fault(mode_fault),
        .mode_fault_clr(mode_fault_clr), .busy(busy), .sclk_i(sclk_w), .mosi_i(mosi_w), .miso_i(miso_w),
        .ss_n_i(ss_n_w), .sclk_pin(sclk_pin), .mosi_pin(mosi_pin), .miso_pin(miso_pin), .ss_pin(ss_pin),
        .gpio_in(gpio_in));
    spipin_partner far (.clk_sys(clk_sys), .sclk_pin(sclk_pin), .mosi_pin(mosi_pin), .miso_pin(miso_pin),
        .ss_pin(ss_pin), .sclk_w(sclk_w), .mosi_w(mosi_w), .miso_w(miso_w), .ss_n_w(ss_n_w));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // collect received words; cut a hang short
    always @(posedge clk_sys)
    begin
        if (rx_valid === 1'b1)
            rxq.push_back(rx_data);
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    // word the slave should send: buffered, else idle
    function automatic logic [7:0] exp_out(input int i);
        return (i < 16) ? ew[i] : spipin_pkg::IDLE_WORD;
    endfunction : exp_out

    // offer one word, held until taken
    task automatic push(input logic [7:0] d);
        tx_valid = 1'b1;
        tx_data = d;
        while (tx_ready !== 1'b1)
            @(negedge clk_sys);
        @(negedge clk_sys);
    endtask : push

    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        seed = 32'h8A29;
        srst = 1'b1;
        cfg = '0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        mode_fault_clr = 1'b0;
        repeat (8) @(negedge clk_sys);
        srst = 1'b0;
        @(negedge clk_sys);
        `CHK("pin_oe", 4'h0, {ss_pin.oe, miso_pin.oe, mosi_pin.oe, sclk_pin.oe})
        `CHK("tx_ready", 1'b1, tx_ready)
        // port function: each pin on its own direction
        cfg.gpio_sel = 4'hF;
        repeat (6)
        begin
            cfg.gpio_dir = 4'($random(seed));
            cfg.gpio_out = 4'($random(seed));
            repeat (6) @(negedge clk_sys);
            `CHK("gpio_oe", cfg.gpio_dir, {ss_pin.oe, miso_pin.oe, mosi_pin.oe, sclk_pin.oe})
            `CHK("gpio_o", cfg.gpio_out, {ss_pin.o, miso_pin.o, mosi_pin.o, sclk_pin.o})
            `CHK("gpio_in", cfg.gpio_out & cfg.gpio_dir, gpio_in & cfg.gpio_dir)
        end
        // master: four back-to-back words against a slave
        cfg = '0;
        far.txsh = 8'($random(seed));
        rp.push_back(far.txsh);
        for (int i = 0; i < 3; i++)
        begin
            rp.push_back(8'($random(seed)));
            far.rep_q.push_back(rp[i + 1]);
        end
        far.s_on = 1'b1;
        cfg.master = 1'b1;
        rxq.delete();
        for (int i = 0; i < 4; i++)
        begin
            ew.push_back(8'($random(seed)));
            push(ew[i]);
        end
        tx_valid = 1'b0;
        repeat (10) @(negedge clk_sys);
        `CHK("busy", 1'b1, busy)
        `CHK("sclk_oe", 1'b1, sclk_pin.oe)
        `CHK("mosi_oe", 1'b1, mosi_pin.oe)
        `CHK("miso_oe", 1'b0, miso_pin.oe)
        k = 0;
        while (far.srx_q.size() < 4 && k < 3000)
        begin
            @(negedge clk_sys);
            k++;
        end
        repeat (10) @(negedge clk_sys);
        for (int i = 0; i < 4; i++)
        begin
            `CHK("mosi_word", ew[i], far.srx_q[i])
            `CHK("miso_word", rp[i], rxq[i])
        end
        `CHK("mosi_early", 0, far.n_late)
        // another master pulls select low
        far.ss_low = 1'b1;
        repeat (6) @(negedge clk_sys);
        `CHK("fault", 1'b1, mode_fault)
        `CHK("fault_oe", 3'h0, {sclk_pin.oe, mosi_pin.oe, miso_pin.oe})
        far.ss_low = 1'b0;
        repeat (4) @(negedge clk_sys);
        mode_fault_clr = 1'b1;
        @(negedge clk_sys);
        mode_fault_clr = 1'b0;
        repeat (4) @(negedge clk_sys);
        `CHK("fault_clr", 1'b0, mode_fault)
        `CHK("sclk_back", 1'b1, sclk_pin.oe)
        // slave: fill the buffer until refused, unselected
        cfg.master = 1'b0;
        far.s_on = 1'b0;
        ew.delete();
        for (int i = 0; i < 16; i++)
        begin
            ew.push_back(8'($random(seed)));
            push(ew[i]);
        end
        tx_data = 8'($random(seed));
        repeat (3) @(negedge clk_sys);
        `CHK("full", 1'b0, tx_ready)
        tx_valid = 1'b0;
        // clocking while unselected must be ignored
        rxq.delete();
        far.mq.push_back(8'($random(seed)));
        far.mxfer(1, 1'b0);
        repeat (6) @(negedge clk_sys);
        `CHK("unsel_rx", 0, rxq.size())
        `CHK("unsel_miso", 1'b0, miso_pin.oe)
        far.mr.delete();
        // selected burst drains all sixteen, then idle word
        rp.delete();
        for (int i = 0; i < 17; i++)
        begin
            rp.push_back(8'($random(seed)));
            far.mq.push_back(rp[i]);
        end
        far.mxfer(17, 1'b1);
        repeat (10) @(negedge clk_sys);
        for (int i = 0; i < 17; i++)
        begin
            `CHK("slave_out", exp_out(i), far.mr[i])
            `CHK("slave_in", rp[i], rxq[i])
        end
        `CHK("desel_miso", 1'b0, miso_pin.oe)
        `CHK("drained", 1'b1, tx_ready)
        report_and_stop();
    end
endmodule : spi_pin_interface_tb
`default_nettype wire
